// ### verilog/ssbp_pkg.sv
// constants shared by the synchronous burst SRAM port
// assumes one 10 MHz clock and an AHB-Lite master for the status registers
//
// Behaviour
// - array of 32768 words of 32 bits, 15-bit address, shared data bus
// - all synchronous inputs captured on the rising clock edge only
// - 2-bit burst counter drives low address bits, upper 13 bits fixed
// - sleep high freezes burst and array state and clears read valid; low again resumes operation
// - burst order pin high gives interleaved order of low bits
// - burst order pin low gives linear modulo-four order of low bits
// - after third step the counter wraps to the loaded low bits
// - bus driven only for reads with output enable low
// - selected only when both low enables low and high enable high
// - strobe low while unselected deselects until next begin burst
// - processor strobe low while selected begins a read burst
// - controller strobe low alone while selected begins read or write burst
// - both strobes high, advance low: continue burst at next address
// - both strobes high, advance high: repeat access at current address
// - write when global write low, or gate low with any lane low
// - byte lanes written per lane enables; global write writes all
// - read after write gives data next cycle; deselect leaves bus floating
// - only a high sleep level or the force sleep control bit selects sleep
// - after a write the bus floats until a new read access
package ssbp_pkg;

    // ========================================
    // array geometry
    localparam int WORD_ADDR_W = 15;
    localparam int WORD_W = 32;
    localparam int LANE_CNT = 4;
    localparam int LANE_W = 8;
    localparam int BURST_W = 2;

    // ========================================
    // register map (byte addresses)
    localparam int REG_AW = 4;
    localparam logic [REG_AW-1:0] OFS_CTRL = 4'h0;
    localparam logic [REG_AW-1:0] OFS_STATUS = 4'h4;
    localparam logic [REG_AW-1:0] OFS_LAST_ADDR = 4'h8;
    localparam logic [REG_AW-1:0] OFS_WR_COUNT = 4'hC;

    // control fields
    localparam int CTRL_FORCE_SLEEP = 0;
    localparam logic CTRL_FORCE_SLEEP_RST = 1'b0;

    // status fields
    localparam int ST_SLEEP = 0;
    localparam int ST_DESEL = 1;
    localparam int ST_RD_VALID = 2;
    localparam int ST_DRIVING = 3;
    localparam int ST_STEP_LSB = 4;
    localparam int ST_BASE_LSB = 6;

    // last address fields
    localparam int LA_WRITE = 31;

    localparam int WR_COUNT_W = 16;

    // ahb encodings
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic HRESP_OKAY = 1'b0;

endpackage : ssbp_pkg

// ### verilog/ssbp_top.sv
// synchronous pipelined burst SRAM core with a small AHB-Lite status block
// assumes pins are synchronous to hclk; the bench resolves the data bus wire
module ssbp_top
    import ssbp_pkg::*;
#(
    parameter int ADDR_W = ssbp_pkg::WORD_ADDR_W,
    parameter int DATA_W = ssbp_pkg::WORD_W,
    parameter int LANES = ssbp_pkg::LANE_CNT
) (
    input wire logic hclk,
    input wire logic hresetn,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic [31:0] hrdata,
    output logic hresp,
    // sram pins
    input wire logic [ADDR_W-1:0] word_address,
    input wire logic processor_addr_strobe_n,
    input wire logic controller_addr_strobe_n,
    input wire logic burst_step_n,
    input wire logic chip_select_n,
    input wire logic secondary_chip_select_n,
    input wire logic secondary_chip_select,
    input wire logic [LANES-1:0] byte_lane_write_n,
    input wire logic byte_write_gate_n,
    input wire logic all_bytes_write_n,
    input wire logic output_enable_n,
    input wire logic burst_order,
    input wire logic sleep_request,
    input wire logic [DATA_W-1:0] shared_data_bus_in,
    output logic [DATA_W-1:0] shared_data_bus_out,
    output logic shared_data_bus_oe
);
    import ssbp_pkg::*;

    localparam int DEPTH = 1 << ADDR_W;
    localparam int LW = DATA_W / LANES;

    // ========================================
    // input registers
    logic in_live;
    logic [ADDR_W-1:0] in_addr;
    logic in_ap_n;
    logic in_ac_n;
    logic in_adv_n;
    logic in_ce_n;
    logic in_ce2_n;
    logic in_ce2;
    logic [LANES-1:0] in_bw_n;
    logic in_bwe_n;
    logic in_gw_n;
    logic in_mode;
    logic [DATA_W-1:0] in_wdata;

    logic force_sleep;
    logic sleep_act;

    assign sleep_act = (sleep_request === 1'b1) || force_sleep;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            in_live <= 1'b0;
            in_addr <= '0;
            in_ap_n <= 1'b1;
            in_ac_n <= 1'b1;
            in_adv_n <= 1'b1;
            in_ce_n <= 1'b1;
            in_ce2_n <= 1'b1;
            in_ce2 <= 1'b0;
            in_bw_n <= '1;
            in_bwe_n <= 1'b1;
            in_gw_n <= 1'b1;
            in_mode <= 1'b0;
            in_wdata <= '0;
        end else if (sleep_act) begin
            in_live <= 1'b0;
        end else begin
            in_live <= 1'b1;
            in_addr <= word_address;
            in_ap_n <= processor_addr_strobe_n;
            in_ac_n <= controller_addr_strobe_n;
            in_adv_n <= burst_step_n;
            in_ce_n <= chip_select_n;
            in_ce2_n <= secondary_chip_select_n;
            in_ce2 <= secondary_chip_select;
            in_bw_n <= byte_lane_write_n;
            in_bwe_n <= byte_write_gate_n;
            in_gw_n <= all_bytes_write_n;
            in_mode <= burst_order;
            in_wdata <= shared_data_bus_in;
        end
    end

    // ========================================
    // cycle decode
    logic selected;
    logic begin_p;
    logic begin_c;
    logic begin_any;
    logic desel_cyc;
    logic cont_cyc;
    logic susp_cyc;
    logic wr_cond;
    logic [LANES-1:0] lane_en;

    assign selected = !in_ce_n && !in_ce2_n && in_ce2;
    assign begin_p = in_live && !in_ap_n && selected;
    assign begin_c = in_live && in_ap_n && !in_ac_n && selected;
    assign begin_any = begin_p || begin_c;
    assign desel_cyc = in_live && (!in_ap_n || !in_ac_n) && !selected;
    assign cont_cyc = in_live && in_ap_n && in_ac_n && !in_adv_n;
    assign susp_cyc = in_live && in_ap_n && in_ac_n && in_adv_n;
    assign wr_cond = !in_gw_n || (!in_bwe_n && !(&in_bw_n));

    genvar g;
    generate
        for (g = 0; g < LANES; g++) begin : g_lane
            assign lane_en[g] = !in_gw_n || (!in_bwe_n && !in_bw_n[g]);
        end
    endgenerate

    // ========================================
    // burst counter
    logic deselected;
    logic [BURST_W-1:0] burst_base;
    logic [BURST_W-1:0] burst_step;
    logic [ADDR_W-BURST_W-1:0] burst_upper;
    logic [BURST_W-1:0] next_step;
    logic [BURST_W-1:0] next_low;
    logic acc_valid;
    logic acc_write;
    logic [ADDR_W-1:0] acc_addr;

    always_comb begin
        next_step = burst_step;
        if (cont_cyc) begin
            next_step = burst_step + 2'h1;
        end
        if (in_mode) begin
            next_low = burst_base ^ next_step;
        end else begin
            next_low = burst_base + next_step;
        end
    end

    assign acc_valid = begin_any || ((cont_cyc || susp_cyc) && !deselected);
    assign acc_write = begin_p ? 1'b0 : wr_cond;
    assign acc_addr = begin_any ? in_addr : {burst_upper, next_low};

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            deselected <= 1'b1;
            burst_base <= '0;
            burst_step <= '0;
            burst_upper <= '0;
        end else if (!sleep_act) begin
            if (begin_any) begin
                deselected <= 1'b0;
                burst_base <= in_addr[BURST_W-1:0];
                burst_step <= '0;
                burst_upper <= in_addr[ADDR_W-1:BURST_W];
            end else if (desel_cyc) begin
                deselected <= 1'b1;
            end else if (cont_cyc && !deselected) begin
                burst_step <= next_step;
            end
        end
    end

    // ========================================
    // array and output register
    logic [DATA_W-1:0] mem [0:DEPTH-1];
    logic [DATA_W-1:0] dout;
    logic rd_valid;

    always_ff @(posedge hclk) begin
        if (!sleep_act && acc_valid && acc_write) begin
            for (int i = 0; i < LANES; i++) begin
                if (lane_en[i]) begin
                    mem[acc_addr][i*LW +: LW] <= in_wdata[i*LW +: LW];
                end
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dout <= '0;
        end else if (!sleep_act && acc_valid && !acc_write) begin
            dout <= mem[acc_addr];
        end
    end

    // read after write, float after deselect
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rd_valid <= 1'b0;
        end else if (sleep_act) begin
            rd_valid <= 1'b0;
        end else begin
            rd_valid <= acc_valid && !acc_write;
        end
    end

    assign shared_data_bus_oe = rd_valid && !output_enable_n && !sleep_act;
    assign shared_data_bus_out = dout;

    // ========================================
    // access tracking
    logic [ADDR_W-1:0] last_addr;
    logic last_write;
    logic [WR_COUNT_W-1:0] wr_count;
    logic wr_count_clr;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            last_addr <= '0;
            last_write <= 1'b0;
        end else if (!sleep_act && acc_valid) begin
            last_addr <= acc_addr;
            last_write <= acc_write;
        end
    end

    // a write in the same cycle as a clear leaves the count at one
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_count <= '0;
        end else if (!sleep_act && acc_valid && acc_write) begin
            wr_count <= wr_count_clr ? WR_COUNT_W'(1) : wr_count + WR_COUNT_W'(1);
        end else if (wr_count_clr) begin
            wr_count <= '0;
        end
    end

    // ========================================
    // ahb-lite slave
    logic ahb_take;
    logic dp_write;
    logic [REG_AW-1:0] dp_addr;
    logic [31:0] rd_mux;
    logic [31:0] status_word;

    assign ahb_take = hsel && hready && (htrans == HTRANS_NONSEQ || htrans == 2'h3);
    assign hreadyout = 1'b1;
    assign hresp = HRESP_OKAY;
    assign wr_count_clr = dp_write && (dp_addr == OFS_WR_COUNT);

    always_comb begin
        status_word = '0;
        status_word[ST_SLEEP] = sleep_act;
        status_word[ST_DESEL] = deselected;
        status_word[ST_RD_VALID] = rd_valid;
        status_word[ST_DRIVING] = shared_data_bus_oe;
        status_word[ST_STEP_LSB +: BURST_W] = burst_step;
        status_word[ST_BASE_LSB +: BURST_W] = burst_base;
    end

    always_comb begin
        rd_mux = '0;
        case (haddr[REG_AW-1:0])
            OFS_CTRL: rd_mux[CTRL_FORCE_SLEEP] = force_sleep;
            OFS_STATUS: rd_mux = status_word;
            OFS_LAST_ADDR: begin
                rd_mux[ADDR_W-1:0] = last_addr;
                rd_mux[LA_WRITE] = last_write;
            end
            OFS_WR_COUNT: rd_mux[WR_COUNT_W-1:0] = wr_count;
            default: rd_mux = '0;
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dp_write <= 1'b0;
            dp_addr <= '0;
            hrdata <= '0;
        end else begin
            dp_write <= ahb_take && hwrite && (haddr[31:REG_AW] == '0);
            if (ahb_take) begin
                dp_addr <= haddr[REG_AW-1:0];
            end
            if (ahb_take && !hwrite) begin
                hrdata <= (haddr[31:REG_AW] == '0) ? rd_mux : 32'h0000_0000;
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            force_sleep <= CTRL_FORCE_SLEEP_RST;
        end else if (dp_write && dp_addr == OFS_CTRL) begin
            force_sleep <= hwdata[CTRL_FORCE_SLEEP];
        end
    end

    // ========================================
    // checks
    AST_BUS_DRIVE: assert property (@(posedge hclk) disable iff (!hresetn)
        shared_data_bus_oe |-> (!output_enable_n && rd_valid && !sleep_act))
        else $error("data bus driven outside a read with output enable low");

    AST_WRITE_FLOAT: assert property (@(posedge hclk) disable iff (!hresetn)
        (acc_valid && acc_write && !sleep_act) |=> !shared_data_bus_oe)
        else $error("data bus driven right after a write");

    AST_READ_LATENCY: assert property (@(posedge hclk) disable iff (!hresetn)
        (acc_valid && !acc_write && !sleep_act) |=> (rd_valid && last_addr == $past(acc_addr)))
        else $error("read data not ready one cycle after the access");

    AST_DESEL_HOLD: assert property (@(posedge hclk) disable iff (!hresetn)
        (deselected && !begin_any) |=> (deselected && !($past(cont_cyc) && rd_valid)))
        else $error("deselect ended without a begin burst");

    AST_BEGIN_LOAD: assert property (@(posedge hclk) disable iff (!hresetn)
        (begin_any && !sleep_act) |=> (burst_step == 2'h0 && burst_base == $past(in_addr[1:0])))
        else $error("begin burst did not load the counter start");

    AST_LINEAR: assert property (@(posedge hclk) disable iff (!hresetn)
        (!in_mode && cont_cyc && !deselected && !sleep_act && $past(acc_valid))
        |=> last_addr[1:0] == $past(burst_base + burst_step + 2'h1))
        else $error("linear burst step wrong");

    AST_INTERLEAVE: assert property (@(posedge hclk) disable iff (!hresetn)
        (in_mode && cont_cyc && !deselected && !sleep_act)
        |=> (last_addr[1:0] ^ burst_base) == burst_step)
        else $error("interleaved burst step wrong");

    AST_UPPER_FIXED: assert property (@(posedge hclk) disable iff (!hresetn)
        (cont_cyc && !deselected && !sleep_act)
        |=> last_addr[ADDR_W-1:BURST_W] == $past(burst_upper))
        else $error("upper address changed inside a burst");

    AST_SUSPEND: assert property (@(posedge hclk) disable iff (!hresetn)
        (susp_cyc && !deselected && !sleep_act ##1 susp_cyc && !deselected && !sleep_act)
        |=> $stable(last_addr))
        else $error("suspend moved the burst address");

    AST_READ_ONLY_GATE: assert property (@(posedge hclk) disable iff (!hresetn)
        (in_gw_n && (in_bwe_n || &in_bw_n)) |-> !wr_cond)
        else $error("write without an active write enable");

    AST_SLEEP_FREEZE: assert property (@(posedge hclk) disable iff (!hresetn)
        sleep_act |=> ($stable(burst_step) && $stable(deselected) && !rd_valid))
        else $error("state moved during sleep");

    AST_PROC_READ: assert property (@(posedge hclk) disable iff (!hresetn)
        (begin_p && !sleep_act) |=> (rd_valid && !last_write))
        else $error("processor begin did not read");

endmodule : ssbp_top

// ### tb/ssbp_ctrl_model.sv
// controller-side model: drives the synchronous pins and the write data
// assumes tb calls drive() right after a rising edge of hclk
module ssbp_ctrl_model (
    input wire logic hclk,
    input wire logic [31:0] dev_out,
    input wire logic dev_oe,
    output logic [14:0] word_address,
    output logic processor_addr_strobe_n,
    output logic controller_addr_strobe_n,
    output logic burst_step_n,
    output logic chip_select_n,
    output logic secondary_chip_select_n,
    output logic secondary_chip_select,
    output logic [3:0] byte_lane_write_n,
    output logic byte_write_gate_n,
    output logic all_bytes_write_n,
    output logic output_enable_n,
    output logic sleep_request,
    output logic burst_order,
    output wire logic [31:0] bus
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [13:0] c_q;
    logic [14:0] a_q;
    logic [31:0] d_q;
    logic [31:0] last;
    logic wr_now;

    initial begin
        c_q = 14'h0E3F;
        a_q = 15'h0;
        d_q = 32'h0;
        last = 32'h0;
        burst_order = 1'b0;
    end

    // ========================================
    // pins
    assign {chip_select_n, secondary_chip_select_n, secondary_chip_select} = c_q[13:11];
    assign {processor_addr_strobe_n, controller_addr_strobe_n, burst_step_n} = c_q[10:8];
    assign {output_enable_n, sleep_request, all_bytes_write_n, byte_write_gate_n} = c_q[7:4];
    assign byte_lane_write_n = c_q[3:0];
    assign word_address = a_q;

    // ========================================
    // data bus, released value never repeats the last one
    assign wr_now = c_q[10] && (!c_q[5] || (!c_q[4] && c_q[3:0] != 4'hF));
    assign bus = dev_oe ? (wr_now ? 32'hXXXX_XXXX : dev_out) : (wr_now ? d_q : ~last);
    always @(posedge hclk) begin
        last <= bus;
    end

    task automatic drive(input logic [13:0] c, input logic [14:0] a, input logic [31:0] d);
        c_q <= c;
        a_q <= a;
        d_q <= d;
    endtask : drive

    task automatic set_order(input logic o);
        burst_order <= o;
    endtask : set_order
endmodule : ssbp_ctrl_model

// ### tb/tb_top.sv
// self-checking bench: AHB register tasks and pin cycles with a shadow model
// assumes one 10 MHz clock and a zero-wait AHB slave
module tb_top;
    import ssbp_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    typedef struct packed {logic k; logic v; logic [31:0] d;} ssbp_ent_t;
    // pin words: ce[13:11] ap ac adv oe_n sleep gw bwe bw[3:0]
    localparam logic [13:0] CONT = 14'h0E3F;
    localparam logic [13:0] SUSP = 14'h0F3F;
    localparam logic [13:0] OEOFF = 14'h0EBF;
    localparam logic [13:0] SLP = 14'h0E7F;
    localparam logic [13:0] RAP = 14'h081F;
    localparam logic [13:0] WBEG = 14'h0C1F;
    localparam logic [13:0] WCON = 14'h0E1F;
    localparam logic [13:0] WCOF = 14'h0E9F;
    localparam logic [13:0] WLANE = 14'h0E2A;
    localparam logic [13:0] RGATE = 14'h0C30;
    localparam logic [13:0] DESL = 14'h2C3F;
    logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, oe;
    logic [31:0] haddr, hwdata, hrdata, dout, bus;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [14:0] wa;
    logic [3:0] bw_n;
    logic ap_n, ac_n, adv_n, ce_n, ce2_n, ce2, bwe_n, gw_n, oe_n, slp, order;
    int fail_count, samples_checked;
    logic [31:0] mem [0:32767];
    logic desel_m, order_m;
    logic [12:0] up;
    logic [1:0] base, stp;
    ssbp_ent_t p0, p1;
    logic [17:0] snap;
    logic snap_wr;
    logic [14:0] snap_ad;
    logic [31:0] snap_old;

    initial begin
        hclk = 1'b0;
        forever #50 hclk = ~hclk;
    end

    ssbp_top i_ssbp_top (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
        .hrdata(hrdata), .hresp(hresp), .word_address(wa), .processor_addr_strobe_n(ap_n),
        .controller_addr_strobe_n(ac_n), .burst_step_n(adv_n), .chip_select_n(ce_n),
        .secondary_chip_select_n(ce2_n), .secondary_chip_select(ce2), .byte_lane_write_n(bw_n),
        .byte_write_gate_n(bwe_n), .all_bytes_write_n(gw_n), .output_enable_n(oe_n),
        .burst_order(order), .sleep_request(slp), .shared_data_bus_in(bus),
        .shared_data_bus_out(dout), .shared_data_bus_oe(oe));

    ssbp_ctrl_model i_ssbp_ctrl_model (.hclk(hclk), .dev_out(dout), .dev_oe(oe), .word_address(wa),
        .processor_addr_strobe_n(ap_n), .controller_addr_strobe_n(ac_n), .burst_step_n(adv_n),
        .chip_select_n(ce_n), .secondary_chip_select_n(ce2_n), .secondary_chip_select(ce2),
        .byte_lane_write_n(bw_n), .byte_write_gate_n(bwe_n), .all_bytes_write_n(gw_n),
        .output_enable_n(oe_n), .sleep_request(slp), .burst_order(order), .bus(bus));

    // ========================================
    // checking and closing
    task automatic stop_test;
        if (fail_count == 0 && samples_checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : stop_test

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            fail_count++;
            $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    // ========================================
    // ahb-lite master
    task automatic wait_rdy;
        int n;
        n = 0;
        do begin
            @(posedge hclk);
            n++;
        end while (hreadyout !== 1'b1 && n < 50);
        if (hreadyout !== 1'b1) begin
            fail_count++;
            stop_test;
        end
    endtask : wait_rdy

    task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] d, output logic [31:0] r);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= HTRANS_NONSEQ;
        haddr <= a;
        hwrite <= w;
        wait_rdy;
        htrans <= 2'h0;
        hwdata <= d;
        wait_rdy;
        r = hrdata;
        chk({31'h0, hresp}, {31'h0, HRESP_OKAY});
    endtask : ahb

    // ========================================
    // one pin cycle, shadow model and two-deep read pipe
    task automatic cyc(input logic [13:0] c, input logic [14:0] a, input logic [31:0] d);
        logic sel, acc, wr;
        logic [14:0] ad;
        @(posedge hclk);
        i_ssbp_ctrl_model.drive(c, a, d);
        if (c[6]) begin
            {desel_m, up, base, stp} = snap;
            if (snap_wr) mem[snap_ad] = snap_old;
            p0.v = 1'b0;
        end
        snap = {desel_m, up, base, stp};
        sel = c[13:11] == 3'b001;
        acc = 1'b0;
        if (c[6]) begin
            acc = 1'b0;
        end else if (!(c[10] && c[9]) && !sel) begin
            desel_m = 1'b1;
        end else if (!(c[10] && c[9])) begin
            desel_m = 1'b0;
            up = a[14:2];
            base = a[1:0];
            stp = 2'h0;
            acc = 1'b1;
        end else if (!desel_m) begin
            acc = 1'b1;
            stp = stp + {1'b0, !c[8]};
        end
        wr = acc && c[10] && (!c[5] || (!c[4] && c[3:0] != 4'hF));
        ad = {up, (order_m ? base ^ stp : base + stp)};
        snap_wr = wr;
        snap_ad = ad;
        snap_old = mem[ad];
        for (int i = 0; i < LANE_CNT; i++) begin
            if (wr && (!c[5] || !c[i])) mem[ad][8*i +: 8] = d[8*i +: 8];
        end
        @(negedge hclk);
        if (c[6]) begin
            chk({31'h0, oe}, 32'h0);
        end else if (p1.k) begin
            chk({31'h0, oe}, {31'h0, p1.v && !c[7]});
            if (p1.v) chk(dout, p1.d);
        end
        p1 = p0;
        p0 = '{k: !c[6], v: acc && !wr, d: mem[ad]};
    endtask : cyc

    task automatic do_reset(input logic o);
        @(posedge hclk);
        hresetn <= 1'b0;
        i_ssbp_ctrl_model.set_order(o);
        repeat (8) @(posedge hclk);
        hresetn <= 1'b1;
        desel_m = 1'b1;
        order_m = o;
        p0 = '0;
        p1 = '0;
        snap = {1'b1, 17'h0};
        snap_wr = 1'b0;
    endtask : do_reset

    // ========================================
    // main sequence
    initial begin
        logic [31:0] r;
        fail_count = 0;
        samples_checked = 0;
        hresetn = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
        do_reset(1'b0);
        ahb(1'b1, 32'h10, 32'hFFFF_FFFF, r);
        ahb(1'b0, 32'h0, 32'h0, r);
        chk(r, 32'h0);
        ahb(1'b0, 32'h10, 32'h0, r);
        chk(r, 32'h0);
        ahb(1'b0, 32'h4, 32'h0, r);
        chk(r & 32'h3, 32'h2);
        ahb(1'b1, 32'h0, 32'h1, r);
        ahb(1'b0, 32'h4, 32'h0, r);
        chk(r & 32'h1, 32'h1);
        ahb(1'b1, 32'h0, 32'h0, r);
        ahb(1'b1, 32'hC, 32'h0, r);
        repeat (2) cyc(CONT, 15'h0, 32'h0);
        cyc(WBEG, 15'h0125, 32'hC0DE_0000);
        for (int i = 1; i < 4; i++) cyc(WCON, 15'h0, 32'hC0DE_0000 + 32'(i));
        cyc(WLANE, 15'h0, 32'h5A5A_5A5A);
        cyc(RAP, 15'h0125, 32'h0);
        repeat (3) cyc(CONT, 15'h0, 32'h0);
        repeat (2) cyc(SUSP, 15'h0, 32'h0);
        cyc(OEOFF, 15'h0, 32'h0);
        cyc(CONT, 15'h0, 32'h0);
        cyc(RGATE, 15'h0126, 32'h0);
        cyc(WCOF, 15'h0, 32'h1234_5678);
        repeat (2) cyc(DESL, 15'h0, 32'h0);
        ahb(1'b0, 32'hC, 32'h0, r);
        chk(r, 32'h6);
        ahb(1'b0, 32'h8, 32'h0, r);
        chk(r, 32'h8000_0127);
        cyc(RAP, 15'h0126, 32'h0);
        cyc(CONT, 15'h0, 32'h0);
        repeat (2) cyc(SLP, 15'h0, 32'h0);
        repeat (3) cyc(CONT, 15'h0, 32'h0);
        repeat (2) cyc(DESL, 15'h0, 32'h0);
        do_reset(1'b1);
        cyc(WBEG, 15'h2346, 32'h0BAD_F00D);
        for (int i = 1; i < 4; i++) cyc(WCON, 15'h0, 32'h0BAD_F00D + 32'(i));
        cyc(RAP, 15'h2346, 32'h0);
        repeat (4) cyc(CONT, 15'h0, 32'h0);
        for (int k = 0; k < 8; k++) cyc({3'(k), RAP[10:0]}, 15'h2347, 32'h0);
        repeat (2) cyc(DESL, 15'h0, 32'h0);
        stop_test;
    end
endmodule : tb_top
